// [cfor_pkg.sv]
package cfor_pkg;
  // ==========================================
  // register map
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_RSVD_A = 6'h1a;
  localparam logic [ADDR_W-1:0] ADDR_RSVD_B = 6'h1b;
  localparam logic [ADDR_W-1:0] ADDR_TX_WAIT = 6'h1c;
  localparam logic [ADDR_W-1:0] ADDR_RX_PAR = 6'h1d;
  localparam logic [ADDR_W-1:0] ADDR_TYPE_B = 6'h1e;
  localparam logic [ADDR_W-1:0] ADDR_UART_RATE = 6'h1f;
  // ==========================================
  // reset values
  localparam logic [DATA_W-1:0] RST_RSVD = 8'h00;
  localparam logic [DATA_W-1:0] RST_TX_WAIT = 8'h62;
  localparam logic [DATA_W-1:0] RST_RX_PAR = 8'h00;
  localparam logic [DATA_W-1:0] RST_TYPE_B = 8'h00;
  localparam logic [DATA_W-1:0] RST_UART_RATE = 8'heb;
  localparam logic [DATA_W-1:0] RDATA_NONE = 8'h00;
  // ==========================================
  // field positions
  localparam int TXW_LSB = 0;
  localparam int TXW_W = 2;
  localparam int PAR_OFF_BIT = 4;
  localparam int SOF_REQ_BIT = 7;
  localparam int EOF_REQ_BIT = 6;
  localparam int DELIM_W_BIT = 4;
  localparam int NO_TX_SOF_BIT = 3;
  localparam int NO_TX_EOF_BIT = 2;
  localparam int EGT_LSB = 0;
  localparam int EGT_W = 2;
  localparam int RATE_C_LSB = 5;
  localparam int RATE_C_W = 3;
  localparam int RATE_F_LSB = 0;
  localparam int RATE_F_W = 5;
  // ==========================================
  // timing
  localparam int WAIT_W = 4;
  localparam logic [WAIT_W-1:0] WAIT_BASE_BITS = 4'h7;
  // ==========================================
  // receive framing states
  typedef enum logic [1:0] {RX_IDLE, RX_TAKE, RX_DROP} cfor_rx_state_type;
endpackage

// [cfor_frame_option_regs.sv]
`timescale 1ns/1ps
// What this block does
// RL1: the response wait in bit periods is the two-bit wait field plus a base of seven.
// RL2: with parity off set, no parity is sent or checked and the parity bit is plain data.
// RL3: with start-delimiter-required set, a Type B stream not opening with a start is ignored.
// RL4: with start-delimiter-required clear, streams with or without a start are taken.
// RL5: with end-delimiter-required set, a stream ending without an end flags a protocol error.
// RL6: with end-delimiter-required clear, streams with or without an end are taken.
// RL7: the delimiter width bit picks the longest delimiters when one, the shortest when zero.
// RL8: the suppress bits stop the start or the end delimiter from being sent.
// RL9: the guard field gives zero to three extra guard bits between sent characters.
// RL10: bits 7 to 5 of the uart rate register give the coarse rate factor.
// RL11: bits 4 to 0 of the uart rate register give the fine rate factor.
// RL12: the uart rate register resets to eb, the parity and Type B registers to 00.
// RL13: the transmit wait register resets to 62 and only its low two bits act.
// RL14: registers 1a and 1b do nothing and reset to 00.
// RL15: the host writes zero to reserved bits and does not trust what they read.
module cfor_frame_option_regs
  import cfor_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic rx_sof_in,
  input wire logic rx_eof_in,
  input wire logic rx_byte_valid_in,
  input wire logic [DATA_W-1:0] rx_byte_in,
  input wire logic rx_parity_err_in,
  input wire logic rx_end_in,
  output logic fifo_wr_out,
  output logic [DATA_W-1:0] fifo_data_out,
  output logic protocol_err_out,
  output logic parity_err_out,
  output logic parity_as_data_out,
  output logic tx_parity_en_out,
  output logic [WAIT_W-1:0] response_wait_bits_out,
  output logic tx_send_sof_out,
  output logic tx_send_eof_out,
  output logic delim_width_max_out,
  output logic [EGT_W-1:0] extra_guard_bits_out,
  output logic [RATE_C_W-1:0] rate_factor_coarse_out,
  output logic [RATE_F_W-1:0] rate_factor_fine_out
);

  // ==========================================
  // register file
  logic [DATA_W-1:0] reserved_slot_a;
  logic [DATA_W-1:0] reserved_slot_b;
  logic [DATA_W-1:0] transmit_wait_config;
  logic [DATA_W-1:0] receive_parity_config;
  logic [DATA_W-1:0] type_b_frame_config;
  logic [DATA_W-1:0] host_uart_rate;

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = reg_wr_in && (reg_addr_in == a);
  endfunction

  // reserved storage is kept so a read returns what was written; nothing uses it
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      reserved_slot_a <= RST_RSVD; // see RL14
      reserved_slot_b <= RST_RSVD; // see RL14
      transmit_wait_config <= RST_TX_WAIT; // see RL13
      receive_parity_config <= RST_RX_PAR; // see RL12
      type_b_frame_config <= RST_TYPE_B; // see RL12
      host_uart_rate <= RST_UART_RATE; // see RL12
    end
    else
    begin
      if (hit(ADDR_RSVD_A))
        reserved_slot_a <= reg_wdata_in;
      if (hit(ADDR_RSVD_B))
        reserved_slot_b <= reg_wdata_in;
      if (hit(ADDR_TX_WAIT))
        transmit_wait_config <= reg_wdata_in;
      if (hit(ADDR_RX_PAR))
        receive_parity_config <= reg_wdata_in;
      if (hit(ADDR_TYPE_B))
        type_b_frame_config <= reg_wdata_in;
      if (hit(ADDR_UART_RATE))
        host_uart_rate <= reg_wdata_in;
    end
  end

  // ==========================================
  // read port, one cycle latency
  logic [DATA_W-1:0] next_rdata;

  always_comb
  begin
    unique case (reg_addr_in)
      ADDR_RSVD_A: next_rdata = reserved_slot_a;
      ADDR_RSVD_B: next_rdata = reserved_slot_b;
      ADDR_TX_WAIT: next_rdata = transmit_wait_config;
      ADDR_RX_PAR: next_rdata = receive_parity_config;
      ADDR_TYPE_B: next_rdata = type_b_frame_config;
      ADDR_UART_RATE: next_rdata = host_uart_rate;
      default: next_rdata = RDATA_NONE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= RDATA_NONE;
    else if (reg_rd_in)
      reg_rdata_out <= next_rdata;
  end

  // ==========================================
  // option fields
  logic parity_off;
  logic start_delim_required;
  logic end_delim_required;
  logic delim_width_max;
  logic tx_start_delim_suppress;
  logic tx_end_delim_suppress;
  logic [TXW_W-1:0] response_wait_extra;
  logic [EGT_W-1:0] extra_guard_bits;
  logic [RATE_C_W-1:0] rate_factor_coarse;
  logic [RATE_F_W-1:0] rate_factor_fine;

  assign parity_off = receive_parity_config[PAR_OFF_BIT];
  assign start_delim_required = type_b_frame_config[SOF_REQ_BIT];
  assign end_delim_required = type_b_frame_config[EOF_REQ_BIT];
  assign delim_width_max = type_b_frame_config[DELIM_W_BIT];
  assign tx_start_delim_suppress = type_b_frame_config[NO_TX_SOF_BIT];
  assign tx_end_delim_suppress = type_b_frame_config[NO_TX_EOF_BIT];
  assign response_wait_extra = transmit_wait_config[TXW_LSB +: TXW_W];
  assign extra_guard_bits = type_b_frame_config[EGT_LSB +: EGT_W];
  assign rate_factor_coarse = host_uart_rate[RATE_C_LSB +: RATE_C_W];
  assign rate_factor_fine = host_uart_rate[RATE_F_LSB +: RATE_F_W];

  // ==========================================
  // transmit side settings, one cycle behind the registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      response_wait_bits_out <= WAIT_BASE_BITS;
      tx_parity_en_out <= 1'b1;
      parity_as_data_out <= 1'b0;
      tx_send_sof_out <= 1'b1;
      tx_send_eof_out <= 1'b1;
      delim_width_max_out <= 1'b0;
      extra_guard_bits_out <= '0;
      rate_factor_coarse_out <= '0;
      rate_factor_fine_out <= '0;
    end
    else
    begin
      response_wait_bits_out <= WAIT_BASE_BITS + WAIT_W'(response_wait_extra); // see RL1
      tx_parity_en_out <= !parity_off; // see RL2
      parity_as_data_out <= parity_off; // see RL2
      tx_send_sof_out <= !tx_start_delim_suppress; // see RL8
      tx_send_eof_out <= !tx_end_delim_suppress; // see RL8
      delim_width_max_out <= delim_width_max; // see RL7
      extra_guard_bits_out <= extra_guard_bits; // see RL9
      rate_factor_coarse_out <= rate_factor_coarse; // see RL10
      rate_factor_fine_out <= rate_factor_fine; // see RL11
    end
  end

  // ==========================================
  // receive framing filter
  // delimiters arrive as pulses and never as bytes, so they are never stored
  cfor_rx_state_type rx_state;
  cfor_rx_state_type next_rx_state;
  logic eof_seen;
  logic end_bad;

  always_comb
  begin
    next_rx_state = rx_state;
    unique case (rx_state)
      RX_IDLE:
      begin
        if (rx_end_in)
          next_rx_state = RX_IDLE;
        else if (rx_sof_in)
          next_rx_state = RX_TAKE; // see RL4
        else if (rx_byte_valid_in && start_delim_required)
          next_rx_state = RX_DROP; // see RL3
        else if (rx_byte_valid_in)
          next_rx_state = RX_TAKE; // see RL4
      end
      RX_TAKE:
      begin
        if (rx_end_in)
          next_rx_state = RX_IDLE;
      end
      RX_DROP:
      begin
        if (rx_end_in)
          next_rx_state = RX_IDLE;
      end
    endcase
  end

  // an end delimiter in the same cycle as the stream end still counts
  assign end_bad = end_delim_required && !(eof_seen || rx_eof_in);

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rx_state <= RX_IDLE;
    else
      rx_state <= next_rx_state;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      eof_seen <= 1'b0;
    else if (rx_end_in)
      eof_seen <= 1'b0;
    else if (rx_eof_in && rx_state == RX_TAKE)
      eof_seen <= 1'b1; // see RL5
  end

  logic take_byte;
  assign take_byte = rx_byte_valid_in && !rx_end_in &&
                     (rx_state == RX_TAKE ||
                      (rx_state == RX_IDLE && !start_delim_required));

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fifo_wr_out <= 1'b0;
      fifo_data_out <= '0;
      parity_err_out <= 1'b0;
    end
    else
    begin
      fifo_wr_out <= take_byte; // see RL3
      if (take_byte)
        fifo_data_out <= rx_byte_in;
      parity_err_out <= take_byte && rx_parity_err_in && !parity_off; // see RL2
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      protocol_err_out <= 1'b0;
    else
      protocol_err_out <= rx_end_in && rx_state == RX_TAKE && end_bad; // see RL5
  end

  // ==========================================
  // checks
  sequence s_wr(logic [ADDR_W-1:0] a);
    reg_wr_in && reg_addr_in == a;
  endsequence

  sequence s_dropped_start;
    rx_state == RX_IDLE && !rx_sof_in && !rx_end_in && rx_byte_valid_in &&
    start_delim_required;
  endsequence

  a_wait_sum: assert property ( // see RL1
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    s_wr(ADDR_TX_WAIT) ##1 !reg_wr_in |=> response_wait_bits_out ==
      WAIT_BASE_BITS + WAIT_W'($past(reg_wdata_in[TXW_LSB +: TXW_W], 2)))
    else $error("response wait not base plus field");

  a_parity_gate: assert property ( // see RL2
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    parity_off |=> !parity_err_out)
    else $error("parity error flagged with parity off");

  a_sof_drop: assert property ( // see RL3
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    s_dropped_start |=> !fifo_wr_out ##0 rx_state == RX_DROP)
    else $error("stream without start was not ignored");

  a_sof_accept: assert property ( // see RL4
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rx_state == RX_IDLE && rx_byte_valid_in && !rx_end_in && !start_delim_required
    |=> fifo_wr_out && fifo_data_out == $past(rx_byte_in))
    else $error("stream without start was not taken");

  a_eof_error: assert property ( // see RL5
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rx_state == RX_TAKE && rx_end_in && end_delim_required && !eof_seen && !rx_eof_in
    |=> protocol_err_out ##1 !protocol_err_out)
    else $error("missing end delimiter not flagged");

  a_eof_accept: assert property ( // see RL6
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !end_delim_required |=> !protocol_err_out)
    else $error("protocol error with end not required");

  a_delim_width: assert property ( // see RL7
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    s_wr(ADDR_TYPE_B) ##1 !reg_wr_in |=>
      delim_width_max_out == $past(reg_wdata_in[DELIM_W_BIT], 2) &&
      tx_send_sof_out == !$past(reg_wdata_in[NO_TX_SOF_BIT], 2))
    else $error("type b transmit settings do not follow write");

  a_guard_bits: assert property ( // see RL9
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    s_wr(ADDR_TYPE_B) ##1 !reg_wr_in |=>
      extra_guard_bits_out == $past(reg_wdata_in[EGT_LSB +: EGT_W], 2))
    else $error("guard bits do not follow write");

  a_rate_split: assert property ( // see RL10
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    s_wr(ADDR_UART_RATE) ##1 !reg_wr_in |=>
      {rate_factor_coarse_out, rate_factor_fine_out} == $past(reg_wdata_in, 2)) // see RL11
    else $error("rate factors do not follow write");

  a_rate_reset: assert property ( // see RL12
    @(posedge clk_sys_in)
    $rose(rst_n_in) |-> host_uart_rate == RST_UART_RATE &&
      transmit_wait_config == RST_TX_WAIT && reserved_slot_a == RST_RSVD) // see RL13
    else $error("register reset value wrong");

  a_eof_suppress: assert property ( // see RL8
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    s_wr(ADDR_TYPE_B) ##1 !reg_wr_in |=>
      tx_send_eof_out == !$past(reg_wdata_in[NO_TX_EOF_BIT], 2))
    else $error("end delimiter suppress does not follow write");

  // a reserved write must leave the wait, parity enable and rate settings alone
  a_rsvd_inert: assert property ( // see RL14
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    reg_wr_in && (reg_addr_in == ADDR_RSVD_A || reg_addr_in == ADDR_RSVD_B) ##1 !reg_wr_in
    |=> $stable(response_wait_bits_out) && $stable(tx_parity_en_out) &&
      $stable(rate_factor_coarse_out) && $stable(rate_factor_fine_out))
    else $error("reserved register write changed a setting");

  a_parity_pair: assert property ( // see RL2
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    parity_err_out |-> fifo_wr_out)
    else $error("parity error without a stored byte");

  a_drop_hold: assert property ( // see RL3
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rx_state == RX_DROP |=> !fifo_wr_out)
    else $error("byte stored from an ignored stream");

endmodule

// [cfor_card_model.sv]
`timescale 1ns/1ps
// ==========================================
// card side: drives decoded receive events one per cycle
module cfor_card_model
  import cfor_pkg::*;
(
  input wire logic clk_sys_in,
  output logic rx_sof_out,
  output logic rx_eof_out,
  output logic rx_byte_valid_out,
  output logic [DATA_W-1:0] rx_byte_out,
  output logic rx_parity_err_out,
  output logic rx_end_out
);
  logic [DATA_W-1:0] last_byte;
  initial
  begin
    rx_sof_out = 1'b0;
    rx_eof_out = 1'b0;
    rx_byte_valid_out = 1'b0;
    rx_byte_out = 8'h5a;
    rx_parity_err_out = 1'b0;
    rx_end_out = 1'b0;
    last_byte = 8'h5a;
  end
  // idle data shows the inverse of the last byte so a stale value never looks valid
  task automatic step(input logic s, input logic e, input logic v, input logic [7:0] d,
                      input logic p, input logic en);
    @(posedge clk_sys_in);
    rx_sof_out <= s;
    rx_eof_out <= e;
    rx_byte_valid_out <= v;
    rx_byte_out <= v ? d : ~last_byte;
    rx_parity_err_out <= v ? p : ~p;
    rx_end_out <= en;
    if (v)
    begin
      last_byte = d;
    end
  endtask
  task automatic frame(input logic sof, input int n, input logic eof, input logic perr);
    if (sof)
    begin
      step(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
    end
    for (int i = 0; i < n; i++)
    begin
      step(1'b0, 1'b0, 1'b1, 8'(8'h11 + i), perr, 1'b0);
    end
    if (eof)
    begin
      step(1'b0, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
    end
    step(1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
    step(1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
  endtask
endmodule

// [tb_contactless_frame_option_regs.sv]
`timescale 1ns/1ps
module tb_contactless_frame_option_regs;
  import cfor_pkg::*;
  logic clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out, fifo_data_out, rx_byte_in;
  logic rx_sof_in, rx_eof_in, rx_byte_valid_in, rx_parity_err_in, rx_end_in;
  logic fifo_wr_out, protocol_err_out, parity_err_out, parity_as_data_out, tx_parity_en_out;
  logic tx_send_sof_out, tx_send_eof_out, delim_width_max_out;
  logic [WAIT_W-1:0] response_wait_bits_out;
  logic [EGT_W-1:0] extra_guard_bits_out;
  logic [RATE_C_W-1:0] rate_factor_coarse_out;
  logic [RATE_F_W-1:0] rate_factor_fine_out;
  logic [7:0] n_wr, n_proto, n_perr;
  logic [ADDR_W-1:0] addrs [6] = '{ADDR_RSVD_A, ADDR_RSVD_B, ADDR_TX_WAIT, ADDR_RX_PAR,
                                   ADDR_TYPE_B, ADDR_UART_RATE};
  logic [7:0] rst_vals [6] = '{8'h00, 8'h00, 8'h62, 8'h00, 8'h00, 8'heb};
  logic [1:0] kb;
  int n_fail = 0;
  int compares = 0;
  cfor_frame_option_regs i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .rx_sof_in(rx_sof_in),
    .rx_eof_in(rx_eof_in), .rx_byte_valid_in(rx_byte_valid_in), .rx_byte_in(rx_byte_in),
    .rx_parity_err_in(rx_parity_err_in), .rx_end_in(rx_end_in), .fifo_wr_out(fifo_wr_out),
    .fifo_data_out(fifo_data_out), .protocol_err_out(protocol_err_out),
    .parity_err_out(parity_err_out), .parity_as_data_out(parity_as_data_out),
    .tx_parity_en_out(tx_parity_en_out), .response_wait_bits_out(response_wait_bits_out),
    .tx_send_sof_out(tx_send_sof_out), .tx_send_eof_out(tx_send_eof_out),
    .delim_width_max_out(delim_width_max_out), .extra_guard_bits_out(extra_guard_bits_out),
    .rate_factor_coarse_out(rate_factor_coarse_out),
    .rate_factor_fine_out(rate_factor_fine_out));
  cfor_card_model i_card (.clk_sys_in(clk_sys_in), .rx_sof_out(rx_sof_in),
    .rx_eof_out(rx_eof_in), .rx_byte_valid_out(rx_byte_valid_in), .rx_byte_out(rx_byte_in),
    .rx_parity_err_out(rx_parity_err_in), .rx_end_out(rx_end_in));
  // ==========================================
  // clock, pulse counters, watchdog
  initial
  begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
  begin
    if (fifo_wr_out === 1'b1) n_wr <= n_wr + 8'h01;
    if (protocol_err_out === 1'b1) n_proto <= n_proto + 8'h01;
    if (parity_err_out === 1'b1) n_perr <= n_perr + 8'h01;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    n_fail++;
    results();
  end
  // ==========================================
  // tasks
  task automatic results();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata_out);
  endtask
  task automatic fr(input logic s, input int n, input logic e, input logic p,
                    input logic [7:0] ew, input logic [7:0] epr, input logic [7:0] epe);
    #1;
    n_wr = 8'h00;
    n_proto = 8'h00;
    n_perr = 8'h00;
    i_card.frame(s, n, e, p);
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk("fifo_writes", ew, n_wr);
    chk("protocol_errs", epr, n_proto);
    chk("parity_errs", epe, n_perr);
    if (ew != 8'h00) chk("fifo_data", 8'(8'h10 + n), fifo_data_out);
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    rst_n_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 6'h00;
    reg_wdata_in = 8'h00;
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    #1;
    for (int i = 0; i < 6; i++) rd(addrs[i], rst_vals[i]);
    rd(6'h20, RDATA_NONE);
    chk("wait_bits", 8'h09, 8'(response_wait_bits_out));
    chk("coarse", 8'h07, 8'(rate_factor_coarse_out));
    chk("fine", 8'h0b, 8'(rate_factor_fine_out));
    wr(ADDR_UART_RATE, 8'ha5);
    chk("coarse", 8'h05, 8'(rate_factor_coarse_out));
    chk("fine", 8'h05, 8'(rate_factor_fine_out));
    wr(6'h20, 8'hff);
    rd(ADDR_UART_RATE, 8'ha5);
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_TX_WAIT, 8'(k));
      chk("wait_bits", 8'(7 + k), 8'(response_wait_bits_out));
    end
    for (int k = 0; k < 4; k++)
    begin
      kb = k[1:0];
      wr(ADDR_TYPE_B, {3'h0, kb[0], kb[1], ~kb[0], kb});
      chk("delim_width", 8'(kb[0]), 8'(delim_width_max_out));
      chk("send_sof", 8'(!kb[1]), 8'(tx_send_sof_out));
      chk("send_eof", 8'(kb[0]), 8'(tx_send_eof_out));
      chk("guard_bits", 8'(kb), 8'(extra_guard_bits_out));
    end
    wr(ADDR_RX_PAR, 8'h10);
    chk("tx_parity_en", 8'h00, 8'(tx_parity_en_out));
    chk("parity_as_data", 8'h01, 8'(parity_as_data_out));
    fr(1'b1, 1, 1'b1, 1'b1, 8'h01, 8'h00, 8'h00);
    wr(ADDR_RX_PAR, 8'h00);
    fr(1'b1, 1, 1'b1, 1'b1, 8'h01, 8'h00, 8'h01);
    wr(ADDR_TYPE_B, 8'h80);
    fr(1'b0, 2, 1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
    fr(1'b1, 2, 1'b1, 1'b0, 8'h02, 8'h00, 8'h00);
    wr(ADDR_TYPE_B, 8'h00);
    fr(1'b0, 2, 1'b0, 1'b0, 8'h02, 8'h00, 8'h00);
    fr(1'b1, 1, 1'b1, 1'b0, 8'h01, 8'h00, 8'h00);
    wr(ADDR_TYPE_B, 8'h40);
    fr(1'b1, 2, 1'b0, 1'b0, 8'h02, 8'h01, 8'h00);
    fr(1'b1, 2, 1'b1, 1'b0, 8'h02, 8'h00, 8'h00);
    wr(ADDR_RSVD_A, 8'h00);
    rd(ADDR_RSVD_A, RST_RSVD);
    chk("wait_bits", 8'h0a, 8'(response_wait_bits_out));
    // reset in mid-run must bring back every reset value
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    #1;
    for (int i = 0; i < 6; i++) rd(addrs[i], rst_vals[i]);
    chk("wait_bits", 8'h09, 8'(response_wait_bits_out));
    chk("coarse", 8'h07, 8'(rate_factor_coarse_out));
    results();
  end
endmodule
